/* File: common/plc_pkg.sv */
// Shared constants for the programmable lookup-table logic cell
package plc_pkg;

  // Geometry
  localparam int unsigned PLC_NUM_SLOTS = 3;
  localparam int unsigned PLC_ROWS      = 8;
  localparam int unsigned PLC_NUM_EXT   = 18;
  localparam int unsigned PLC_NUM_SRC   = 19;
  localparam int unsigned PLC_SRC_W     = 5;
  localparam int unsigned PLC_ACT_W     = 3;
  localparam int unsigned PLC_SLOT_W    = 2;
  localparam int unsigned PLC_ROW_W     = 3;
  localparam int unsigned PLC_ADDR_W    = 4;
  localparam int unsigned PLC_DATA_W    = 8;

  // Register offsets
  localparam logic [3:0] PLC_OFF_TABLE_CHOICE = 4'h0;
  localparam logic [3:0] PLC_OFF_SLOT_CHOICE  = 4'h1;
  localparam logic [3:0] PLC_OFF_INPUT_SOURCE = 4'h2;
  localparam logic [3:0] PLC_OFF_INPUT_ACT    = 4'h3;
  localparam logic [3:0] PLC_OFF_TABLE_ALL    = 4'h4;
  localparam logic [3:0] PLC_OFF_ROW_INDEX    = 4'h5;
  localparam logic [3:0] PLC_OFF_ROW_VALUE    = 4'h6;
  localparam logic [3:0] PLC_OFF_STATUS       = 4'h7;

  // Status field positions
  localparam int unsigned PLC_ST_OUT  = 0;
  localparam int unsigned PLC_ST_QUAL = 1;
  localparam int unsigned PLC_ST_DATA = 4;
  localparam int unsigned PLC_ST_GATE = 5;

  // Table choice codes
  localparam logic PLC_TBL_DATA = 1'b0;
  localparam logic PLC_TBL_GATE = 1'b1;

  // Activation codes
  localparam logic [2:0] PLC_ACT_LOW_LEVEL   = 3'h0;
  localparam logic [2:0] PLC_ACT_HIGH_LEVEL  = 3'h1;
  localparam logic [2:0] PLC_ACT_FALL        = 3'h2;
  localparam logic [2:0] PLC_ACT_RISE        = 3'h3;
  localparam logic [2:0] PLC_ACT_EITHER_EDGE = 3'h4;

  // Limits and reset values
  localparam logic [4:0] PLC_SRC_MAX    = 5'h12;
  localparam logic [1:0] PLC_SLOT_MAX   = 2'h2;
  localparam logic [4:0] PLC_RST_SRC    = 5'h00;
  localparam logic [2:0] PLC_RST_ACT    = 3'h1;
  localparam logic [7:0] PLC_RST_TABLE  = 8'h00;

endpackage

/* File: hdl/plc_slot.sv */
// One shared table input: source pick and activation qualifier
module plc_slot
  import plc_pkg::*;
(
  // Conditioned source samples, bit 0 is the constant zero source
  input  wire logic [PLC_NUM_SRC-1:0] cur_in,
  input  wire logic [PLC_NUM_SRC-1:0] prev_in,
  // Slot settings
  input  wire logic [PLC_SRC_W-1:0]   src_sel_in,
  input  wire logic [PLC_ACT_W-1:0]   act_in,
  // Qualified input
  output logic                        qual_out
);

  logic now_v;
  logic was_v;

  always_comb begin
    now_v = cur_in[src_sel_in];
    was_v = prev_in[src_sel_in];
    case (act_in)
      PLC_ACT_LOW_LEVEL:   qual_out = !now_v;
      PLC_ACT_HIGH_LEVEL:  qual_out = now_v;
      PLC_ACT_FALL:        qual_out = was_v && !now_v;
      PLC_ACT_RISE:        qual_out = !was_v && now_v;
      PLC_ACT_EITHER_EDGE: qual_out = was_v != now_v;
      default:             qual_out = 1'b0;
    endcase
  end

endmodule

/* File: hdl/plc_cell.sv */
// Programmable logic cell: two shared-input lookup tables and output flip-flop
//
// Contract
// - Two tables and one flop; data_table feeds D, gate_table feeds enable.
// - Each table has three inputs and an eight-bit truth table.
// - The three input selections are shared by both tables.
// - Each input has a source choice and an activation choice.
// - Activation: low level, high level, falling, rising or either edge.
// - Row index is input2 msb down to input0 lsb; bit n is row n.
// - Writing lut_table_all replaces the whole selected table at once.
// - lut_row_index picks a row; lut_row_value reads or writes that bit.
// - Output holds while gate_table is false, loads data_table while true.
// - Gate table of all ones makes the output follow data_table.
//
// Added by the designer: the register addresses and the strobed register port.
module plc_cell
  import plc_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // Register port
  input  wire logic [PLC_ADDR_W-1:0]  addr_in,
  input  wire logic [PLC_DATA_W-1:0]  wr_data_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [PLC_DATA_W-1:0]  rd_data_out,
  // Internal signal sources
  input  wire logic [PLC_NUM_EXT-1:0] src_in,
  // Cell output
  output logic                        cell_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Source conditioning

  logic [PLC_NUM_EXT-1:0] sync1_q, sync2_q, sync3_q, filt_q, prev_q;
  logic [PLC_NUM_EXT-1:0] sync1_d, sync2_d, sync3_d, filt_d, prev_d;

  always_comb begin
    sync1_d = src_in;
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    // A change counts only once the last two stages agree
    filt_d  = (sync2_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));
    prev_d  = filt_q;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q  <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      filt_q  <= filt_d;
      prev_q  <= prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic                  table_choice_q, table_choice_d;
  logic [PLC_SLOT_W-1:0] slot_choice_q, slot_choice_d;
  logic [PLC_ROW_W-1:0]  row_index_q, row_index_d;
  logic [PLC_ROWS-1:0]   data_tbl_q, data_tbl_d;
  logic [PLC_ROWS-1:0]   gate_tbl_q, gate_tbl_d;
  logic [PLC_SRC_W-1:0]  src_sel_q [PLC_NUM_SLOTS];
  logic [PLC_SRC_W-1:0]  src_sel_d [PLC_NUM_SLOTS];
  logic [PLC_ACT_W-1:0]  act_q [PLC_NUM_SLOTS];
  logic [PLC_ACT_W-1:0]  act_d [PLC_NUM_SLOTS];
  logic [PLC_ROWS-1:0]   sel_tbl;

  function automatic logic hit(input logic [PLC_ADDR_W-1:0] off);
    return addr_in == off;
  endfunction

  assign sel_tbl = (table_choice_q == PLC_TBL_GATE) ? gate_tbl_q : data_tbl_q;

  always_comb begin
    table_choice_d = table_choice_q;
    slot_choice_d  = slot_choice_q;
    row_index_d    = row_index_q;
    data_tbl_d     = data_tbl_q;
    gate_tbl_d     = gate_tbl_q;
    src_sel_d      = src_sel_q;
    act_d          = act_q;
    if (wr_in) begin
      if (hit(PLC_OFF_TABLE_CHOICE)) begin
        table_choice_d = wr_data_in[0];
      end
      if (hit(PLC_OFF_SLOT_CHOICE) && wr_data_in[1:0] <= PLC_SLOT_MAX) begin
        slot_choice_d = wr_data_in[1:0];
      end
      // Input settings ignore the table choice: both tables see them
      if (hit(PLC_OFF_INPUT_SOURCE) && wr_data_in[4:0] <= PLC_SRC_MAX) begin
        src_sel_d[slot_choice_q] = wr_data_in[4:0];
      end
      if (hit(PLC_OFF_INPUT_ACT) && wr_data_in[2:0] <= PLC_ACT_EITHER_EDGE) begin
        act_d[slot_choice_q] = wr_data_in[2:0];
      end
      if (hit(PLC_OFF_ROW_INDEX)) begin
        row_index_d = wr_data_in[2:0];
      end
      if (hit(PLC_OFF_TABLE_ALL)) begin
        if (table_choice_q == PLC_TBL_GATE) begin
          gate_tbl_d = wr_data_in;
        end else begin
          data_tbl_d = wr_data_in;
        end
      end
      if (hit(PLC_OFF_ROW_VALUE)) begin
        if (table_choice_q == PLC_TBL_GATE) begin
          gate_tbl_d[row_index_q] = wr_data_in[0];
        end else begin
          data_tbl_d[row_index_q] = wr_data_in[0];
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      table_choice_q <= PLC_TBL_DATA;
      slot_choice_q  <= '0;
      row_index_q    <= '0;
      data_tbl_q     <= PLC_RST_TABLE;
      gate_tbl_q     <= PLC_RST_TABLE;
      for (int i = 0; i < PLC_NUM_SLOTS; i++) begin
        src_sel_q[i] <= PLC_RST_SRC;
        act_q[i]     <= PLC_RST_ACT;
      end
    end else begin
      table_choice_q <= table_choice_d;
      slot_choice_q  <= slot_choice_d;
      row_index_q    <= row_index_d;
      data_tbl_q     <= data_tbl_d;
      gate_tbl_q     <= gate_tbl_d;
      src_sel_q      <= src_sel_d;
      act_q          <= act_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared inputs and table lookup

  logic [PLC_NUM_SLOTS-1:0] qual;
  logic                     data_res;
  logic                     gate_res;
  logic [PLC_NUM_SRC-1:0]   cur_src;
  logic [PLC_NUM_SRC-1:0]   prev_src;

  // Code 0 is the constant zero source
  assign cur_src  = {filt_q, 1'b0};
  assign prev_src = {prev_q, 1'b0};

  genvar g;
  generate
    for (g = 0; g < PLC_NUM_SLOTS; g++) begin : g_slot
      plc_slot u_slot (
        .cur_in     (cur_src),
        .prev_in    (prev_src),
        .src_sel_in (src_sel_q[g]),
        .act_in     (act_q[g]),
        .qual_out   (qual[g])
      );
    end
  endgenerate

  // Input 2 is the row msb
  assign data_res = data_tbl_q[qual];
  assign gate_res = gate_tbl_q[qual];

  ////////////////////////////////////////////////////////////////////////////////
  // Output flop and read data

  logic                  out_q, out_d;
  logic [PLC_DATA_W-1:0] rd_q, rd_d;

  always_comb begin
    out_d = gate_res ? data_res : out_q;
    rd_d  = '0;
    if (rd_in) begin
      case (addr_in)
        PLC_OFF_TABLE_CHOICE: rd_d[0]   = table_choice_q;
        PLC_OFF_SLOT_CHOICE:  rd_d[1:0] = slot_choice_q;
        PLC_OFF_INPUT_SOURCE: rd_d[4:0] = src_sel_q[slot_choice_q];
        PLC_OFF_INPUT_ACT:    rd_d[2:0] = act_q[slot_choice_q];
        PLC_OFF_TABLE_ALL:    rd_d      = sel_tbl;
        PLC_OFF_ROW_INDEX:    rd_d[2:0] = row_index_q;
        PLC_OFF_ROW_VALUE:    rd_d[0]   = sel_tbl[row_index_q];
        PLC_OFF_STATUS: begin
          rd_d[PLC_ST_OUT]                  = out_q;
          rd_d[PLC_ST_QUAL +: PLC_NUM_SLOTS] = qual;
          rd_d[PLC_ST_DATA]                 = data_res;
          rd_d[PLC_ST_GATE]                 = gate_res;
        end
        default:              rd_d      = '0;
      endcase
    end
  end

  // Hold and load on the same logic clock as edge detection
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_q <= 1'b0;
      rd_q  <= '0;
    end else begin
      out_q <= out_d;
      rd_q  <= rd_d;
    end
  end

  assign cell_out    = out_q;
  assign rd_data_out = rd_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  out_hold_a: assert property (!gate_res |=> cell_out == $past(cell_out))
    else $error("output changed while gate table false");
  out_load_a: assert property (gate_res |=> cell_out == $past(data_res))
    else $error("output did not load data table result");
  gate_bypass_a: assert property (gate_tbl_q == 8'hff |=> cell_out == $past(data_res))
    else $error("all-ones gate table did not pass data through");
  table_all_a: assert property (wr_in && addr_in == PLC_OFF_TABLE_ALL |=>
      sel_tbl == $past(wr_data_in) && table_choice_q == $past(table_choice_q))
    else $error("whole-table write not loaded");
  row_write_a: assert property (wr_in && addr_in == PLC_OFF_ROW_VALUE
      && table_choice_q == PLC_TBL_DATA |=>
      data_tbl_q[$past(row_index_q)] == $past(wr_data_in[0]) && gate_tbl_q == $past(gate_tbl_q))
    else $error("row write wrong");
  row_order_a: assert property (qual == 3'b001 |-> data_res == data_tbl_q[1])
    else $error("table row order wrong");
  shared_src_a: assert property (wr_in && addr_in == PLC_OFF_INPUT_SOURCE
      && wr_data_in[4:0] <= PLC_SRC_MAX |=>
      src_sel_q[$past(slot_choice_q)] == $past(wr_data_in[4:0]))
    else $error("shared input source not updated");
  high_level_a: assert property (act_q[0] == PLC_ACT_HIGH_LEVEL
      |-> qual[0] == cur_src[src_sel_q[0]])
    else $error("high level activation wrong");
  rise_pulse_a: assert property (act_q[0] == PLC_ACT_RISE && qual[0] && !wr_in
      |=> !qual[0])
    else $error("rising edge input lasted past one cycle");
  status_read_a: assert property (rd_in && addr_in == PLC_OFF_STATUS
      |=> rd_data_out[PLC_ST_OUT] == $past(cell_out) && rd_data_out[7:6] == 2'h0)
    else $error("status read wrong");

endmodule

/* File: sim/test_plc_cell.sv */
// Self-checking testbench for the lookup-table logic cell
module test_plc_cell
  import plc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk_in = 1'b0;
  logic                   rst_in = 1'b1;
  logic [PLC_ADDR_W-1:0]  addr_in = 4'h0;
  logic [PLC_DATA_W-1:0]  wr_data_in = 8'h00;
  logic                   wr_in = 1'b0;
  logic                   rd_in = 1'b0;
  logic [PLC_DATA_W-1:0]  rd_data_out;
  logic [PLC_NUM_EXT-1:0] src_in = 18'h00000;
  logic                   cell_out;
  int                     err_total = 0;
  int                     n_compared = 0;

  plc_cell u_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .src_in(src_in),
    .cell_out(cell_out));

  always #2.5 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rd_data_out, exp);
  endtask

  task automatic settle();
    repeat (8) @(posedge clk_in);
    #1;
  endtask

  task automatic pulses(output int c);
    c = 0;
    repeat (10) begin
      @(posedge clk_in);
      #1;
      if (cell_out === 1'b1) c++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] exp [0:8];
    exp = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rd_chk(4'(i), exp[i]);
    @(posedge clk_in);
    #1;
    chk(rd_data_out, 8'h00);
  endtask

  task automatic t_tables();
    wr(4'h0, 8'h00);
    wr(4'h4, 8'hc0);
    rd_chk(4'h4, 8'hc0);
    wr(4'h5, 8'h02);
    wr(4'h6, 8'h01);
    rd_chk(4'h4, 8'hc4);
    wr(4'h5, 8'h07);
    rd_chk(4'h6, 8'h01);
    wr(4'h0, 8'h01);
    rd_chk(4'h4, 8'h00);
    wr(4'h4, 8'hff);
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h5a);
    rd_chk(4'h4, 8'h5a);
    wr(4'h0, 8'h01);
    rd_chk(4'h4, 8'hff);
  endtask

  task automatic t_shared();
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h02);
    wr(4'h2, 8'h05);
    wr(4'h3, 8'h03);
    wr(4'h0, 8'h01);
    rd_chk(4'h2, 8'h05);
    rd_chk(4'h3, 8'h03);
    wr(4'h2, 8'h13);
    rd_chk(4'h2, 8'h05);
    wr(4'h1, 8'h03);
    rd_chk(4'h1, 8'h02);
    wr(4'h9, 8'hff);
    rd_chk(4'h9, 8'h00);
    wr(4'h2, 8'h12);
    rd_chk(4'h2, 8'h12);
    wr(4'h3, 8'h05);
    rd_chk(4'h3, 8'h03);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h01);
  endtask

  // Gate all ones, data follows input 0 fed by source 1
  task automatic t_act();
    int r;
    int f;
    int er [2:4] = '{0, 1, 1};
    int ef [2:4] = '{1, 0, 1};
    wr(4'h0, 8'h01);
    wr(4'h4, 8'hff);
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h02);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h01);
    for (int a = 0; a < 5; a++) begin
      src_in <= 18'h00000;
      wr(4'h3, 8'(a));
      settle();
      if (a < 2) begin
        src_in[0] <= 1'b1;
        settle();
        chk({7'h00, cell_out}, {7'h00, a == 1});
        rd_chk(4'h7, (a == 1) ? 8'h33 : 8'h20);
      end else begin
        src_in[0] <= 1'b1;
        pulses(r);
        src_in[0] <= 1'b0;
        pulses(f);
        chk(8'(r), 8'(er[a]));
        chk(8'(f), 8'(ef[a]));
      end
    end
  endtask

  // Data is input 0, gate is input 1: output must latch while gate is false
  task automatic t_hold();
    wr(4'h3, 8'h01);
    wr(4'h1, 8'h01);
    wr(4'h2, 8'h02);
    wr(4'h3, 8'h01);
    wr(4'h0, 8'h00);
    wr(4'h4, 8'haa);
    wr(4'h0, 8'h01);
    wr(4'h4, 8'hcc);
    src_in <= 18'h00003;
    settle();
    chk({7'h00, cell_out}, 8'h01);
    src_in <= 18'h00001;
    settle();
    src_in <= 18'h00000;
    settle();
    chk({7'h00, cell_out}, 8'h01);
    src_in <= 18'h00002;
    settle();
    chk({7'h00, cell_out}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #50us;
    err_total++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_tables();
    t_shared();
    t_act();
    t_hold();
    test_done();
  end
endmodule
